// ---- hdl/itra_target.sv ----
`timescale 1ns/1ps
module itra_target (
	input  logic       sys_clk_i,
	input  logic       reset_i,
	input  logic       scl_clk_i,
	input  logic       sda_i,
	input  logic       addr_sel_i,
	input  logic       hs_mode_i,
	input  logic       addr_valid_i,
	input  logic [7:0] rd_data_i,
	output logic       sda_o,
	output logic       sda_oe_n_o,
	output logic [7:0] rd_addr_o,
	output logic       reg_wr_o,
	output logic [7:0] reg_waddr_o,
	output logic [7:0] reg_wdata_o,
	output logic       bus_busy_o
);
	import itra_pkg::*;

	// ---------------- system clock side ----------------
	// pin synchronisers, order {scl, sda, addr_sel, hs_mode}
	logic [3:0]  sync1_r;
	logic [3:0]  sync2_r;
	logic        scl_s;
	logic        sda_s;
	logic        sel_s;
	logic        hs_s;

	logic        sda_del_r;
	logic        sda_del_nxt;
	logic [6:0]  hold_cnt_r;
	logic [6:0]  hold_cnt_nxt;
	logic [6:0]  hold_lim;
	logic        del_upd;
	logic        start_evt;
	logic        stop_evt;
	itra_bus_t   state_r;
	itra_bus_t   state_nxt;
	logic        link_rst_r;
	logic        link_rst_nxt;
	logic        wtgl1_r;
	logic        wtgl2_r;
	logic        wtgl3_r;
	logic        wr_edge;
	logic        reg_wr_r;
	logic        reg_wr_nxt;
	logic [7:0]  reg_waddr_r;
	logic [7:0]  reg_waddr_nxt;
	logic [7:0]  reg_wdata_r;
	logic [7:0]  reg_wdata_nxt;
	logic        addr_lsb_r;
	logic        addr_lsb_nxt;
	logic        bus_busy_r;
	logic        bus_busy_nxt;
	logic        sda_o_r;
	logic        sda_o_nxt;

	// ---------------- link clock side ----------------
	logic [3:0]  bit_cnt_r;
	logic [3:0]  bit_cnt_nxt;
	logic [7:0]  shift_r;
	logic [7:0]  shift_nxt;
	logic [7:0]  rx_byte;
	itra_phase_t phase_r;
	itra_phase_t phase_nxt;
	logic [7:0]  ptr_r;
	logic [7:0]  ptr_nxt;
	logic        wr_tgl_r;
	logic        wr_tgl_nxt;
	logic [7:0]  wr_addr_r;
	logic [7:0]  wr_addr_nxt;
	logic [7:0]  wr_data_r;
	logic [7:0]  wr_data_nxt;
	logic        sda_oe_n_r;
	logic        sda_oe_n_nxt;
	logic [7:0]  tx_r;
	logic [7:0]  tx_nxt;

	assign scl_s = sync2_r[3];
	assign sda_s = sync2_r[2];
	assign sel_s = sync2_r[1];
	assign hs_s  = sync2_r[0];

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync1_r <= PIN_SYNC_RST;
			sync2_r <= PIN_SYNC_RST;
		end else begin
			sync1_r <= {scl_clk_i, sda_i, addr_sel_i, hs_mode_i};
			sync2_r <= sync1_r;
		end
	end

	// sda is delayed by the hold time so a data edge right after scl falls
	// is not mistaken for a bus condition; changes while scl is low are plain data
	always_comb begin
		hold_lim     = hs_s ? HS_HOLD_LIM : FS_HOLD_LIM;
		hold_cnt_nxt = HOLD_CNT_RST;
		sda_del_nxt  = sda_s;
		del_upd      = 1'b0;
		if (sda_s != sda_del_r && scl_s) begin
			// only a change that scl stays high across counts as a condition
			sda_del_nxt = sda_del_r;
			if (hold_cnt_r >= hold_lim - 7'h01) begin
				del_upd     = 1'b1;
				sda_del_nxt = sda_s;
			end else begin
				hold_cnt_nxt = hold_cnt_r + 7'h01;
			end
		end
		start_evt = del_upd && !sda_s && scl_s;
		stop_evt  = del_upd && sda_s && scl_s;
	end

	always_comb begin
		state_nxt    = state_r;
		link_rst_nxt = link_rst_r;
		if (stop_evt) begin
			state_nxt    = BUS_IDLE;
			link_rst_nxt = 1'b1;
		end else if (start_evt) begin
			// also a repeated start: counters restart, pointer survives
			state_nxt    = BUS_ARMED;
			link_rst_nxt = 1'b1;
		end else begin
			unique case (state_r)
				BUS_ARMED: begin
					// release only while scl is low, so no scl edge meets the release
					if (!scl_s) begin
						state_nxt    = BUS_ACTIVE;
						link_rst_nxt = 1'b0;
					end
				end
				BUS_IDLE, BUS_ACTIVE: begin
				end
			endcase
		end
	end

	// write words are stable in the link domain long before the toggle arrives
	always_comb begin
		wr_edge       = wtgl3_r != wtgl2_r;
		reg_wr_nxt    = wr_edge;
		reg_waddr_nxt = wr_edge ? wr_addr_r : reg_waddr_r;
		reg_wdata_nxt = wr_edge ? wr_data_r : reg_wdata_r;
		addr_lsb_nxt  = sel_s;
		bus_busy_nxt  = state_nxt != BUS_IDLE;
		sda_o_nxt     = 1'b0;
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sda_del_r   <= 1'b1;
			hold_cnt_r  <= HOLD_CNT_RST;
			state_r     <= BUS_IDLE;
			link_rst_r  <= 1'b1;
			wtgl1_r     <= 1'b0;
			wtgl2_r     <= 1'b0;
			wtgl3_r     <= 1'b0;
			reg_wr_r    <= 1'b0;
			reg_waddr_r <= PTR_RST;
			reg_wdata_r <= BYTE_ZERO;
			addr_lsb_r  <= 1'b0;
			bus_busy_r  <= 1'b0;
			sda_o_r     <= 1'b0;
		end else begin
			sda_del_r   <= sda_del_nxt;
			hold_cnt_r  <= hold_cnt_nxt;
			state_r     <= state_nxt;
			link_rst_r  <= link_rst_nxt;
			wtgl1_r     <= wr_tgl_r;
			wtgl2_r     <= wtgl1_r;
			wtgl3_r     <= wtgl2_r;
			reg_wr_r    <= reg_wr_nxt;
			reg_waddr_r <= reg_waddr_nxt;
			reg_wdata_r <= reg_wdata_nxt;
			addr_lsb_r  <= addr_lsb_nxt;
			bus_busy_r  <= bus_busy_nxt;
			sda_o_r     <= sda_o_nxt;
		end
	end

	// ---------------- link clock: sampling on scl rising ----------------
	always_comb begin
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt   = shift_r;
		phase_nxt   = phase_r;
		rx_byte     = {shift_r[6:0], sda_i};
		if (bit_cnt_r == BIT_ACK) begin
			// no byte counter anywhere: transfers run as long as the controller wants
			bit_cnt_nxt = BIT_FIRST;
			unique case (phase_r)
				PH_ADDR:   phase_nxt = sda_oe_n_r ? PH_IGNORE : (shift_r[0] ? PH_RDATA : PH_PTR);
				PH_PTR:    phase_nxt = PH_WDATA;
				PH_RDATA:  phase_nxt = sda_i ? PH_IGNORE : PH_RDATA;
				PH_WDATA, PH_IGNORE: begin
				end
			endcase
		end else begin
			bit_cnt_nxt = bit_cnt_r + 4'h1;
			shift_nxt   = rx_byte;
		end
	end

	always_ff @(posedge scl_clk_i or posedge link_rst_r) begin
		if (link_rst_r) begin
			bit_cnt_r <= BIT_FIRST;
			shift_r   <= BYTE_ZERO;
			phase_r   <= PH_ADDR;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
			shift_r   <= shift_nxt;
			phase_r   <= phase_nxt;
		end
	end

	// pointer and write hand-off only see reset_i, so they outlive every frame
	always_comb begin
		ptr_nxt     = ptr_r;
		wr_tgl_nxt  = wr_tgl_r;
		wr_addr_nxt = wr_addr_r;
		wr_data_nxt = wr_data_r;
		if (bit_cnt_r == BIT_LSB && phase_r == PH_PTR) begin
			ptr_nxt = rx_byte;
		end
		if (bit_cnt_r == BIT_ACK && (phase_r == PH_WDATA || phase_r == PH_RDATA)) begin
			// eight-bit wrap covers the whole range
			ptr_nxt = ptr_r + 8'h01;
		end
		if (bit_cnt_r == BIT_ACK && phase_r == PH_WDATA && !sda_oe_n_r) begin
			wr_tgl_nxt  = !wr_tgl_r;
			wr_addr_nxt = ptr_r;
			wr_data_nxt = shift_r;
		end
	end

	always_ff @(posedge scl_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ptr_r     <= PTR_RST;
			wr_tgl_r  <= 1'b0;
			wr_addr_r <= PTR_RST;
			wr_data_r <= BYTE_ZERO;
		end else begin
			ptr_r     <= ptr_nxt;
			wr_tgl_r  <= wr_tgl_nxt;
			wr_addr_r <= wr_addr_nxt;
			wr_data_r <= wr_data_nxt;
		end
	end

	// ---------------- link clock: driving on scl falling ----------------
	// addr_valid_i and rd_data_i must settle within half an scl period
	always_comb begin
		sda_oe_n_nxt = 1'b1;
		tx_nxt       = tx_r;
		unique case (phase_r)
			PH_ADDR: begin
				if (bit_cnt_r == BIT_ACK && shift_r[7:1] == {DEV_ADDR_HI, addr_lsb_r}) begin
					sda_oe_n_nxt = 1'b0;
				end
			end
			PH_PTR, PH_WDATA: begin
				if (bit_cnt_r == BIT_ACK) begin
					sda_oe_n_nxt = !addr_valid_i;
				end
			end
			PH_RDATA: begin
				if (bit_cnt_r == BIT_FIRST) begin
					tx_nxt       = addr_valid_i ? rd_data_i : BYTE_ZERO;
					sda_oe_n_nxt = tx_nxt[7];
				end else if (bit_cnt_r != BIT_ACK) begin
					tx_nxt       = {tx_r[6:0], 1'b1};
					sda_oe_n_nxt = tx_nxt[7];
				end
			end
			PH_IGNORE: begin
			end
		endcase
	end

	always_ff @(negedge scl_clk_i or posedge link_rst_r) begin
		if (link_rst_r) begin
			sda_oe_n_r <= 1'b1;
			tx_r       <= BYTE_ZERO;
		end else begin
			sda_oe_n_r <= sda_oe_n_nxt;
			tx_r       <= tx_nxt;
		end
	end

	assign sda_o       = sda_o_r;
	assign sda_oe_n_o  = sda_oe_n_r;
	assign rd_addr_o   = ptr_r;
	assign reg_wr_o    = reg_wr_r;
	assign reg_waddr_o = reg_waddr_r;
	assign reg_wdata_o = reg_wdata_r;
	assign bus_busy_o  = bus_busy_r;

	// ---------------- assertions ----------------
	sequence s_bad_load;
		phase_r == PH_RDATA && bit_cnt_r == BIT_FIRST && !addr_valid_i;
	endsequence

	sequence s_zero_byte;
		(!sda_oe_n_r) [*8];
	endsequence

	a_start_arms_link: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		start_evt && !stop_evt |=> state_r == BUS_ARMED && link_rst_r ##[1:1000] (!link_rst_r || state_r == BUS_IDLE))
		else $error("start did not arm the link");

	a_stop_ends_frame: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		stop_evt |=> state_r == BUS_IDLE && link_rst_r && !bus_busy_o)
		else $error("stop did not end the transfer");

	a_restart_keeps_ptr: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		start_evt && state_r == BUS_ACTIVE |=> link_rst_r && $stable(ptr_r))
		else $error("repeated start lost the pointer");

	a_hold_before_cond: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		$changed(sda_del_r) && $past(scl_s) |-> $past(hold_cnt_r) + 7'h01 >= HS_HOLD_LIM)
		else $error("bus condition seen before hold time");

	a_idle_released: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_r == BUS_IDLE && link_rst_r |-> sda_oe_n_r && sda_o == 1'b0)
		else $error("data line pulled while bus idle");

	a_write_strobe: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		wr_edge |=> reg_wr_o && reg_wdata_o == wr_data_r ##1 !reg_wr_o)
		else $error("write strobe wrong");

	a_ptr_increment: assert property (@(posedge scl_clk_i) disable iff (link_rst_r)
		bit_cnt_r == BIT_ACK && (phase_r == PH_WDATA || phase_r == PH_RDATA) |=> ptr_r == $past(ptr_r) + 8'h01)
		else $error("pointer did not advance after data byte");

	a_ptr_load: assert property (@(posedge scl_clk_i) disable iff (link_rst_r)
		bit_cnt_r == BIT_LSB && phase_r == PH_PTR |=> ptr_r == $past(rx_byte))
		else $error("pointer not loaded from first written byte");

	a_nack_continues: assert property (@(posedge scl_clk_i) disable iff (link_rst_r)
		bit_cnt_r == BIT_ACK && phase_r == PH_PTR |=> phase_r == PH_WDATA && bit_cnt_r == BIT_FIRST)
		else $error("transfer not continued after pointer byte");

	a_no_invalid_write: assert property (@(posedge scl_clk_i) disable iff (link_rst_r)
		bit_cnt_r == BIT_ACK && phase_r == PH_WDATA && sda_oe_n_r |=> $stable(wr_tgl_r))
		else $error("invalid write was stored");

	a_zero_read: assert property (@(negedge scl_clk_i) disable iff (link_rst_r)
		s_bad_load |=> s_zero_byte)
		else $error("invalid read not all zeros");

	a_addr_ack: assert property (@(negedge scl_clk_i) disable iff (link_rst_r)
		phase_r == PH_ADDR && bit_cnt_r == BIT_ACK && shift_r[7:1] != {DEV_ADDR_HI, addr_lsb_r} |=> sda_oe_n_r)
		else $error("foreign address acknowledged");

endmodule : itra_target

// ---- hdl/itra_pkg.sv ----
package itra_pkg;

	localparam int          SYS_PERIOD_NS  = 5;
	localparam int          FS_HOLD_NS     = 300;
	localparam int          HS_HOLD_NS     = 80;
	localparam int          HS_HOLD_MAX_NS = 150;
	localparam int          FS_HOLD_CYC    = (FS_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int          HS_HOLD_CYC    = (HS_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int          HS_HOLD_MAXCYC = HS_HOLD_MAX_NS / SYS_PERIOD_NS;
	localparam logic [6:0]  FS_HOLD_LIM    = 7'(FS_HOLD_CYC);
	localparam logic [6:0]  HS_HOLD_LIM    = 7'(HS_HOLD_CYC);
	localparam logic [6:0]  HOLD_CNT_RST   = 7'h00;
	localparam logic [5:0]  DEV_ADDR_HI    = 6'h20;
	localparam logic [3:0]  BIT_FIRST      = 4'h0;
	localparam logic [3:0]  BIT_LSB        = 4'h7;
	localparam logic [3:0]  BIT_ACK        = 4'h8;
	localparam logic [7:0]  PTR_RST        = 8'h00;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;
	localparam logic [3:0]  PIN_SYNC_RST   = 4'hc;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_ARMED,
		BUS_ACTIVE
	} itra_bus_t;

	typedef enum logic [2:0] {
		PH_ADDR,
		PH_PTR,
		PH_WDATA,
		PH_RDATA,
		PH_IGNORE
	} itra_phase_t;

endpackage : itra_pkg

// ---- verification/itra_host_model.sv ----
`timescale 1ns/1ps
module itra_host_model (
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// start/stop hold on the data line, long enough for the target's filter
	int hold_ns = 400;

	initial begin
		scl_o     = 1'b1;
		sda_low_o = 1'b0;
	end

	// also serves as repeated start: data released before the clock rises
	task automatic start();
		#4 sda_low_o = 1'b0;
		#12 scl_o = 1'b1;
		#200 sda_low_o = 1'b1;
		#(hold_ns) scl_o = 1'b0;
		#100;
	endtask : start

	// data moves 4ns after the clock falls so the sync never sees the data change before the clock fall
	task automatic clk_bit(input logic low, output logic seen);
		#4 sda_low_o = low;
		#12 scl_o = 1'b1;
		#8 seen = sda_i;
		#8 scl_o = 1'b0;
	endtask : clk_bit

	task automatic send_byte(input logic [7:0] b, output logic ack_n);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(~b[i], s);
		clk_bit(1'b0, ack_n);
	endtask : send_byte

	task automatic recv_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b0, s);
			b[i] = s;
		end
		clk_bit(~last, s);
	endtask : recv_byte

	task automatic stop();
		#4 sda_low_o = 1'b1;
		#12 scl_o = 1'b1;
		#(hold_ns) sda_low_o = 1'b0;
		#600;
	endtask : stop
endmodule : itra_host_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic       sys_clk;
	logic       reset;
	logic       scl;
	logic       sda;
	logic       host_low;
	logic       addr_sel;
	logic       hs_mode;
	logic       addr_valid;
	logic [7:0] rd_data;
	logic       sda_out;
	logic       sda_oe_n;
	logic [7:0] rd_addr;
	logic       reg_wr;
	logic [7:0] reg_waddr;
	logic [7:0] reg_wdata;
	logic       bus_busy;
	logic [7:0] mem [256];
	int         n_wr;
	int         miscompares;
	int         n_checks;
	int         cyc;

	// pull-up on the data line
	assign sda        = (host_low | (sda_oe_n === 1'b0)) ? 1'b0 : 1'b1;
	// arbitrary map: 0x00-0x1f valid
	assign addr_valid = (rd_addr < 8'h20);
	assign rd_data    = rd_addr ^ 8'hc3;

	itra_target i_itra_target (
		.sys_clk_i   (sys_clk),
		.reset_i     (reset),
		.scl_clk_i   (scl),
		.sda_i       (sda),
		.addr_sel_i  (addr_sel),
		.hs_mode_i   (hs_mode),
		.addr_valid_i(addr_valid),
		.rd_data_i   (rd_data),
		.sda_o       (sda_out),
		.sda_oe_n_o  (sda_oe_n),
		.rd_addr_o   (rd_addr),
		.reg_wr_o    (reg_wr),
		.reg_waddr_o (reg_waddr),
		.reg_wdata_o (reg_wdata),
		.bus_busy_o  (bus_busy)
	);

	itra_host_model i_host (
		.sda_i    (sda),
		.scl_o    (scl),
		.sda_low_o(host_low)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (reg_wr === 1'b1) begin
			mem[reg_waddr] <= reg_wdata;
			n_wr           <= n_wr + 1;
		end
	end

	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report();
		if (miscompares == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	task automatic sc_write_valid();
		logic a;
		i_host.start();
		chk({7'h00, bus_busy}, 8'h01);
		i_host.send_byte(8'h80, a);
		chk({7'h00, a}, 8'h00);
		i_host.send_byte(8'h10, a);
		chk({7'h00, a}, 8'h00);
		chk(rd_addr, 8'h10);
		i_host.send_byte(8'ha5, a);
		chk({7'h00, a}, 8'h00);
		i_host.send_byte(8'h3c, a);
		chk({7'h00, a}, 8'h00);
		i_host.stop();
		chk(mem[8'h10], 8'ha5);
		chk(mem[8'h11], 8'h3c);
		chk(rd_addr, 8'h12);
		chk({7'h00, bus_busy}, 8'h00);
		chk({7'h00, sda_oe_n}, 8'h01);
	endtask : sc_write_valid

	task automatic sc_write_invalid();
		logic a;
		int   w0 = n_wr;
		i_host.start();
		i_host.send_byte(8'h80, a);
		i_host.send_byte(8'hfe, a);
		chk({7'h00, a}, 8'h01);
		i_host.send_byte(8'h11, a);
		chk({7'h00, a}, 8'h01);
		i_host.send_byte(8'h22, a);
		chk({7'h00, a}, 8'h01);
		i_host.send_byte(8'h33, a);
		chk({7'h00, a}, 8'h00);
		i_host.stop();
		chk(mem[8'h00], 8'h33);
		chk(8'(n_wr - w0), 8'h01);
		chk(rd_addr, 8'h01);
	endtask : sc_write_invalid

	task automatic sc_read_current();
		logic       a;
		logic [7:0] b;
		i_host.start();
		i_host.send_byte(8'h81, a);
		chk({7'h00, a}, 8'h00);
		i_host.recv_byte(1'b0, b);
		chk(b, 8'h01 ^ 8'hc3);
		i_host.recv_byte(1'b1, b);
		chk(b, 8'h02 ^ 8'hc3);
		i_host.stop();
		chk(rd_addr, 8'h03);
	endtask : sc_read_current

	task automatic sc_read_wrap();
		logic       a;
		logic [7:0] b;
		i_host.start();
		i_host.send_byte(8'h80, a);
		i_host.send_byte(8'hff, a);
		chk({7'h00, a}, 8'h01);
		i_host.start();
		i_host.send_byte(8'h81, a);
		chk({7'h00, a}, 8'h00);
		i_host.recv_byte(1'b0, b);
		chk(b, 8'h00);
		i_host.recv_byte(1'b0, b);
		chk(b, 8'hc3);
		i_host.recv_byte(1'b1, b);
		chk(b, 8'h01 ^ 8'hc3);
		i_host.stop();
		chk(rd_addr, 8'h02);
	endtask : sc_read_wrap

	// strap high plus short hold: only the 0x41 address answers
	task automatic sc_select_hs();
		logic a;
		@(negedge sys_clk);
		addr_sel = 1'b1;
		hs_mode  = 1'b1;
		i_host.hold_ns = 150;
		i_host.start();
		i_host.send_byte(8'h80, a);
		chk({7'h00, a}, 8'h01);
		i_host.stop();
		i_host.start();
		i_host.send_byte(8'h82, a);
		chk({7'h00, a}, 8'h00);
		i_host.send_byte(8'h05, a);
		i_host.send_byte(8'h77, a);
		chk({7'h00, a}, 8'h00);
		i_host.stop();
		chk(mem[8'h05], 8'h77);
		chk({7'h00, sda_out}, 8'h00);
	endtask : sc_select_hs

	initial begin
		reset       = 1'b1;
		addr_sel    = 1'b0;
		hs_mode     = 1'b0;
		miscompares = 0;
		n_checks    = 0;
		n_wr        = 0;
		cyc         = 0;
		repeat (10) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 1'b0;
		repeat (5) @(negedge sys_clk);
		// keeps link edges off the system clock grid
		#1.3;
		sc_write_valid();
		sc_write_invalid();
		sc_read_current();
		sc_read_wrap();
		sc_select_hs();
		final_report();
	end
endmodule : tb_top
